/* bench/jlf_link_asserts.sv */
// Checker on the link between the formatter and its receiver
`timescale 1ns/100ps
`default_nettype none
module jlf_link_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link signals
  input wire logic [2:0] testSel,
  input wire logic altLane,
  input wire logic opModePd,
  input wire logic [7:0][47:0] laneData,
  input wire logic [7:0] laneDrvEn,
  input wire logic laneValid,
  input wire logic linkLayerOn
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_pd; opModePd |=> laneDrvEn == 8'h00 && !laneValid; endproperty
  a_pd: assert property (p_pd) else $error("pd");
  // The select reaches the device only once the link is down, so its first two frames are spared
  property p_alt; altLane && $past(altLane, 2) && laneValid |-> laneDrvEn[3:0] == 4'h0; endproperty
  a_alt: assert property (p_alt) else $error("alt");
  property p_byp; laneValid && testSel inside {[3'h1:3'h6]} |-> !linkLayerOn; endproperty
  a_byp: assert property (p_byp) else $error("bypass");
  property p_rmp; laneValid && testSel == 3'h7 |-> linkLayerOn && laneData[3] == laneData[0]; endproperty
  a_rmp: assert property (p_rmp) else $error("ramp");
  property p_clk; laneValid && testSel == 3'h6 |-> laneData[0] == 48'hFF00FF00FF00; endproperty
  a_clk: assert property (p_clk) else $error("clock");
  property p_inc; laneValid && $past(laneValid) && testSel == 3'h7 |->
    laneData[0][47:40] == $past(laneData[0][47:40]) + 8'h06; endproperty
  a_inc: assert property (p_inc) else $error("step");
  property p_p7; laneValid && testSel == 3'h1 |-> laneData[0][40:0] == (laneData[0][46:6] ^ laneData[0][47:7]);
  endproperty
  a_p7: assert property (p_p7) else $error("prbs7");
  property p_p9; laneValid && testSel == 3'h2 |-> laneData[0][38:0] == (laneData[0][43:5] ^ laneData[0][47:9]);
  endproperty
  a_p9: assert property (p_p9) else $error("prbs9");
endmodule
`default_nettype wire

/* bench/test_jesd204c_lane_format_and_test_patterns.sv */
// Bench joining the lane formatter to its receiver
`timescale 1ns/100ps
`default_nettype none
module test_jesd204c_lane_format_and_test_patterns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0][15:0][8:0] samples;
  logic [32:0] rd;
  logic [47:0] w;
  logic [47:0] e;
  logic [7:0][47:0] rxd;
  logic rxv;
  logic rdy;
  int mismatches = 0;
  int check_count = 0;
  jlf_link_if lnk();
  jlf_device #(.NUM_CH(1), .ILA_CYC(4), .INIT_CYC(3)) jlf_device_i (.clk, .sys_rst, .link(lnk), .samples,
    .sampleValid(1'b1), .sampleReady(rdy), .linkUp());
  jlf_host #(.FLUSH_CYC(5)) jlf_host_i (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .link(lnk), .rxData(rxd), .rxValid(rxv));
  jlf_link_asserts jlf_link_asserts_i (.clk, .sys_rst, .testSel(lnk.testSel), .altLane(lnk.altLane),
    .opModePd(lnk.opModePd), .laneData(lnk.laneData), .laneDrvEn(lnk.laneDrvEn), .laneValid(lnk.laneValid),
    .linkLayerOn(lnk.linkLayerOn));
  always #25 clk = ~clk;
  task chk(input string n, input logic [47:0] s, input logic [47:0] x);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Config is only taken while the link is off, so it goes in before the enable
  task up(input logic [31:0] c, input logic [6:0] f);
    apb(1'b1, 12'h000, c);
    apb(1'b1, 12'h004, {25'h0, f});
    apb(1'b1, 12'h000, c | 32'h1);
    repeat (200) if (lnk.laneValid !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    w = lnk.laneData[0];
  endtask
  task t_map(input logic [3:0] m, input logic [47:0] x, input logic [7:0] dv);
    up(32'h60, {3'h0, m});
    chk("lane0", w, x);
    chk("drv", 48'(lnk.laneDrvEn), 48'(dv));
    chk("hdr", 48'(lnk.syncHdr), 48'(m != 4'hD));
    @(posedge clk);
    #1;
    chk("rx", rxd[0], x);
    chk("rxvalid", 48'(rxv), 48'h1);
    apb(1'b1, 12'h000, 32'h60);
  endtask
  task t_misc;
    up(32'h60, 7'h6F);
    chk("clock", w, 48'hFF00FF00FF00);
    up(32'h60, 7'h7F);
    chk("ramp", w, 48'h000102030405);
    chk("ready", 48'(rdy), 48'h0);
    up(32'h78, 7'h0F);
    chk("alt", lnk.laneData[4], e);
    chk("fec", 48'(lnk.syncHdr), 48'h2);
    apb(1'b1, 12'h000, 32'h7B);
    repeat (6) @(posedge clk);
    #1;
    chk("pdpin", 48'(lnk.laneDrvEn), 48'h0);
    up(32'h78, 7'h0F);
    chk("relink", lnk.laneData[4], e);
    apb(1'b1, 12'h000, 32'h75);
    repeat (2) @(posedge clk);
    #1;
    chk("pd", 48'(lnk.laneDrvEn), 48'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("cfg", 48'(rd), 48'h0F);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 48'(rd), 48'h100000000);
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b0, 12'h000, 32'h0);
    chk("chen", 48'(rd), 48'h64);
  endtask
  task t_prbs;
    int ta[5] = '{6, 5, 14, 18, 28};
    int tb[5] = '{7, 9, 15, 23, 31};
    for (int i = 0; i < 5; i++) begin
      up(32'h60, {3'(i + 1), 4'hF});
      e = w;
      for (int p = 0; p + tb[i] < 48; p++) e[p] = w[p + ta[i]] ^ w[p + tb[i]];
      chk("prbs", w, e);
      chk("phase", 48'(lnk.laneData[1] === w), 48'h0);
    end
  endtask
  task tally_and_finish;
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    samples = '0;
    for (int s = 0; s < 16; s++) samples[0][s] = 9'(s * 37 + 5);
    e = {samples[0][0], 3'h0, samples[0][4], 3'h0, 24'h0};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_map(4'hF, e, 8'h0F);
    t_map(4'hD, {samples[0][0], 1'b0, samples[0][4], 1'b0, samples[0][8], 1'b0, samples[0][12], 9'h0}, 8'h0F);
    t_map(4'hC, {samples[0][0][8:1], 40'h0}, 8'h0F);
    t_map(4'hE, {samples[0][0], 3'h0, samples[0][2], 3'h0, 24'h0}, 8'h03);
    t_misc;
    t_prbs;
    apb(1'b0, 12'h00C, 32'h0);
    chk("errors", 48'(rd), 48'h0);
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* common/jlf_link_if.sv */
// Lane bundle and side-band controls between the formatter and its receiver
`timescale 1ns/100ps
`default_nettype none
interface jlf_link_if;
  // Receiver to formatter
  logic linkEnable;
  logic [3:0] linkMode;
  logic [2:0] testSel;
  logic altLane;
  logic [1:0] chanPairEn;
  logic syncFec;
  logic opModePd;
  logic pwrDownPin;
  // Formatter to receiver
  logic [jlf_pkg::NUM_LANES-1:0][jlf_pkg::LANE_W-1:0] laneData;
  logic [jlf_pkg::NUM_LANES-1:0] laneDrvEn;
  logic laneValid;
  logic linkLayerOn;
  logic [1:0] syncHdr;

  modport dev(input linkEnable, linkMode, testSel, altLane, chanPairEn, syncFec, opModePd, pwrDownPin,
              output laneData, laneDrvEn, laneValid, linkLayerOn, syncHdr);
  modport host(output linkEnable, linkMode, testSel, altLane, chanPairEn, syncFec, opModePd, pwrDownPin,
               input laneData, laneDrvEn, laneValid, linkLayerOn, syncHdr);
endinterface
`default_nettype wire

/* common/jlf_pkg.sv */
// Shared constants, types and the test-sequence generator for the lane formatter and its receiver
package jlf_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NUM_LANES = 8;
  localparam int LANE_GROUP = 4;
  localparam int LANE_W = 48;
  localparam int MAX_CH = 4;
  localparam int SAMPS = 16;
  localparam int SAMP_W = 9;
  localparam int OCTET = 8;
  localparam int SLOT10 = 10;
  localparam int SLOT12 = 12;
  localparam int PAD1_W = 1;
  localparam int PAD3_W = 3;
  localparam int PRBS_W = 31;

  // ****************************************************************
  // Link modes and test patterns
  // ****************************************************************
  localparam logic [3:0] MODE_8B_66 = 4'hC;
  localparam logic [3:0] MODE_9B_8B10 = 4'hD;
  localparam logic [3:0] MODE_9B_66_PAIR = 4'hE;
  localparam logic [3:0] MODE_9B_66 = 4'hF;

  localparam logic [2:0] TEST_OFF = 3'h0;
  localparam logic [2:0] TEST_PRBS7 = 3'h1;
  localparam logic [2:0] TEST_PRBS9 = 3'h2;
  localparam logic [2:0] TEST_PRBS15 = 3'h3;
  localparam logic [2:0] TEST_PRBS23 = 3'h4;
  localparam logic [2:0] TEST_PRBS31 = 3'h5;
  localparam logic [2:0] TEST_CLOCK = 3'h6;
  localparam logic [2:0] TEST_RAMP = 3'h7;

  localparam logic [15:0] CLK_PATTERN = 16'hFF00;
  localparam int CLK_PAT_W = 16;
  localparam logic [7:0] RAMP_STEP = 8'h06;

  localparam logic [1:0] SYNC_NONE = 2'h0;
  localparam logic [1:0] SYNC_CRC12 = 2'h1;
  localparam logic [1:0] SYNC_FEC = 2'h2;

  typedef enum logic [1:0] {LINK_DOWN, LINK_INIT, LINK_RUN} jlf_link_state_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 20;
  localparam int ILA_NS = 3200;
  localparam int SERDES_INIT_NS = 1600;
  localparam int FLUSH_NS = 5000;
  localparam int ILA_CYC = (ILA_NS * CLK_MHZ + 999) / 1000;
  localparam int SERDES_INIT_CYC = (SERDES_INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int FLUSH_CYC = (FLUSH_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;

  // ****************************************************************
  // Controller registers
  // ****************************************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CFG = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam logic [11:0] REG_ERR = 12'h00C;
  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_PD = 1;
  localparam int CTRL_OP_PD = 2;
  localparam int CTRL_FEC = 3;
  localparam int CTRL_ALT = 4;
  localparam int CTRL_CHEN_LO = 5;
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_TEST_LO = 4;
  localparam int STAT_VALID = 0;
  localparam int STAT_FLUSH = 1;
  localparam int STAT_LINK_LAYER = 2;
  localparam int STAT_DRV_LO = 8;
  localparam logic [1:0] CHEN_RST = 2'h3;

  // Taps of y[n] = y[n-a] ^ y[n-b]
  function automatic int tapA(input logic [2:0] t);
    unique case (t)
      TEST_PRBS7: tapA = 6;
      TEST_PRBS9: tapA = 5;
      TEST_PRBS15: tapA = 14;
      TEST_PRBS23: tapA = 18;
      default: tapA = 28;
    endcase
  endfunction

  function automatic int tapB(input logic [2:0] t);
    unique case (t)
      TEST_PRBS7: tapB = 7;
      TEST_PRBS9: tapB = 9;
      TEST_PRBS15: tapB = 15;
      TEST_PRBS23: tapB = 23;
      default: tapB = 31;
    endcase
  endfunction

  // Returns {next history, word}; history bit 0 is the newest bit, word is sent MSB first
  function automatic logic [PRBS_W+LANE_W-1:0] prbsStep(input logic [PRBS_W-1:0] hist, input logic [2:0] t);
    logic [PRBS_W+LANE_W-1:0] v;
    int a;
    int b;
    v = {hist, {LANE_W{1'b0}}};
    a = tapA(t);
    b = tapB(t);
    for (int p = LANE_W - 1; p >= 0; p--) begin
      v[p] = v[p+a] ^ v[p+b];
    end
    prbsStep = {v[PRBS_W-1:0], v[LANE_W-1:0]};
  endfunction

endpackage

/* hw/jlf_device.sv */
// Converter-side lane formatter with serializer test-pattern generators
`timescale 1ns/100ps
`default_nettype none

module jlf_device #(
  parameter int NUM_CH = 2,
  parameter int ILA_CYC = jlf_pkg::ILA_CYC,
  parameter int INIT_CYC = jlf_pkg::SERDES_INIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link to the receiver
  jlf_link_if.dev link,
  // Converter samples, one frame per channel
  input wire logic [jlf_pkg::MAX_CH-1:0][jlf_pkg::SAMPS-1:0][jlf_pkg::SAMP_W-1:0] samples,
  input wire logic sampleValid,
  output logic sampleReady,
  output logic linkUp
);

  // ****************************************************************
  // Configuration, held across power-down
  // ****************************************************************
  logic [3:0] modeReg;
  logic [2:0] testReg;
  logic altReg;
  logic [1:0] chenReg;
  logic fecReg;

  // Only sampled while the link is off, so a live link never sees a pattern switch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      modeReg <= jlf_pkg::MODE_9B_8B10;
      testReg <= jlf_pkg::TEST_OFF;
      altReg <= 1'b0;
      chenReg <= jlf_pkg::CHEN_RST;
      fecReg <= 1'b0;
    end else if (!link.linkEnable) begin
      modeReg <= link.linkMode;
      testReg <= link.testSel;
      altReg <= link.altLane;
      chenReg <= link.chanPairEn;
      fecReg <= link.syncFec;
    end
  end

  // ****************************************************************
  // Power-down pin synchroniser
  // ****************************************************************
  logic pdS1;
  logic pdS2;
  logic pdS3;
  logic pdLevel;
  logic powerDown;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pdS1 <= 1'b0;
      pdS2 <= 1'b0;
      pdS3 <= 1'b0;
      pdLevel <= 1'b0;
    end else begin
      pdS1 <= link.pwrDownPin;
      pdS2 <= pdS1;
      pdS3 <= pdS2;
      if (pdS2 == pdS3) begin
        pdLevel <= pdS3;
      end
    end
  end

  assign powerDown = pdLevel | link.opModePd;

  // ****************************************************************
  // Link start-up
  // ****************************************************************
  jlf_pkg::jlf_link_state_t state;
  logic [jlf_pkg::CNT_W-1:0] initCnt;
  logic [jlf_pkg::CNT_W-1:0] initLen;
  logic isPrbs;
  logic isBypass;

  assign initLen = (modeReg == jlf_pkg::MODE_9B_8B10) ? jlf_pkg::CNT_W'(ILA_CYC) : jlf_pkg::CNT_W'(INIT_CYC);
  assign isPrbs = (testReg >= jlf_pkg::TEST_PRBS7) && (testReg <= jlf_pkg::TEST_PRBS31);
  assign isBypass = isPrbs || (testReg == jlf_pkg::TEST_CLOCK);

  // Any power-down drops the link so the receiver must realign
  always_ff @(posedge clk) begin
    if (sys_rst || powerDown || !link.linkEnable) begin
      state <= jlf_pkg::LINK_DOWN;
      initCnt <= '0;
    end else begin
      unique case (state)
        jlf_pkg::LINK_DOWN: begin
          state <= jlf_pkg::LINK_INIT;
          initCnt <= '0;
        end
        jlf_pkg::LINK_INIT: begin
          initCnt <= initCnt + 1'b1;
          if (initCnt == initLen - 1'b1) begin
            state <= jlf_pkg::LINK_RUN;
          end
        end
        jlf_pkg::LINK_RUN: state <= jlf_pkg::LINK_RUN;
      endcase
    end
  end

  assign linkUp = (state == jlf_pkg::LINK_RUN);
  assign sampleReady = linkUp && (testReg == jlf_pkg::TEST_OFF);

  // ****************************************************************
  // Sample-to-lane map
  // ****************************************************************
  logic [jlf_pkg::NUM_LANES-1:0][jlf_pkg::LANE_W-1:0] built;
  logic [jlf_pkg::NUM_LANES-1:0] laneOn;
  int laneCount;

  always_comb begin
    built = '0;
    for (int l = 0; l < jlf_pkg::NUM_LANES; l++) begin
      unique case (modeReg)
        jlf_pkg::MODE_8B_66: begin
          built[l][jlf_pkg::LANE_W-1 -: jlf_pkg::OCTET] =
            samples[l / jlf_pkg::LANE_GROUP][l % jlf_pkg::LANE_GROUP][jlf_pkg::SAMP_W-1 -: jlf_pkg::OCTET];
        end
        jlf_pkg::MODE_9B_8B10: begin
          for (int j = 0; j < jlf_pkg::LANE_GROUP; j++) begin
            built[l][jlf_pkg::LANE_W-1-jlf_pkg::SLOT10*j -: jlf_pkg::SLOT10] =
              {samples[l / jlf_pkg::LANE_GROUP][l % jlf_pkg::LANE_GROUP + jlf_pkg::LANE_GROUP*j],
               {jlf_pkg::PAD1_W{1'b0}}};
          end
        end
        jlf_pkg::MODE_9B_66_PAIR: begin
          for (int j = 0; j < 2; j++) begin
            built[l][jlf_pkg::LANE_W-1-jlf_pkg::SLOT12*j -: jlf_pkg::SLOT12] =
              {samples[l / 2][l % 2 + 2*j], {jlf_pkg::PAD3_W{1'b0}}};
          end
        end
        jlf_pkg::MODE_9B_66: begin
          for (int j = 0; j < 2; j++) begin
            built[l][jlf_pkg::LANE_W-1-jlf_pkg::SLOT12*j -: jlf_pkg::SLOT12] =
              {samples[l / jlf_pkg::LANE_GROUP][l % jlf_pkg::LANE_GROUP + jlf_pkg::LANE_GROUP*j],
               {jlf_pkg::PAD3_W{1'b0}}};
          end
        end
        default: built[l] = '0;
      endcase
    end
  end

  // Lane count comes from the link mode and NUM_CH only, whatever test pattern runs
  always_comb begin
    if (modeReg == jlf_pkg::MODE_9B_66_PAIR) begin
      laneCount = 2 * NUM_CH;
    end else begin
      laneCount = (NUM_CH >= 2) ? jlf_pkg::NUM_LANES : jlf_pkg::LANE_GROUP;
    end
    for (int l = 0; l < jlf_pkg::NUM_LANES; l++) begin
      if (modeReg == jlf_pkg::MODE_9B_66_PAIR) begin
        laneOn[l] = (l < laneCount) && chenReg[l / jlf_pkg::LANE_GROUP];
      end else begin
        laneOn[l] = (l < laneCount) && chenReg[l / (2 * jlf_pkg::LANE_GROUP)];
      end
    end
  end

  // ****************************************************************
  // Test pattern generators
  // ****************************************************************
  logic [jlf_pkg::NUM_LANES-1:0][jlf_pkg::LANE_W-1:0] prbsWord;
  logic [jlf_pkg::NUM_LANES-1:0][jlf_pkg::PRBS_W-1:0] prbsHist;
  logic [7:0] rampCnt;
  logic [jlf_pkg::LANE_W-1:0] rampWord;

  genvar g;
  generate
    for (g = 0; g < jlf_pkg::NUM_LANES; g++) begin : gPrbs
      logic [jlf_pkg::PRBS_W+jlf_pkg::LANE_W-1:0] step;
      assign step = jlf_pkg::prbsStep(prbsHist[g], testReg);
      // Word comes straight from the history so the first valid frame already follows the sequence
      assign prbsWord[g] = step[jlf_pkg::LANE_W-1:0];
      // A different seed per lane gives each lane its own phase of the sequence
      always_ff @(posedge clk) begin
        if (sys_rst || !isPrbs || state == jlf_pkg::LINK_DOWN) begin
          prbsHist[g] <= jlf_pkg::PRBS_W'(g + 1);
        end else begin
          prbsHist[g] <= step[jlf_pkg::PRBS_W+jlf_pkg::LANE_W-1:jlf_pkg::LANE_W];
        end
      end
    end
  endgenerate

  // Ramp holds at zero until the link reaches the running state
  always_ff @(posedge clk) begin
    if (sys_rst || state != jlf_pkg::LINK_RUN) begin
      rampCnt <= '0;
    end else begin
      rampCnt <= rampCnt + jlf_pkg::RAMP_STEP;
    end
  end

  always_comb begin
    for (int o = 0; o < jlf_pkg::LANE_W / jlf_pkg::OCTET; o++) begin
      rampWord[jlf_pkg::LANE_W-1-jlf_pkg::OCTET*o -: jlf_pkg::OCTET] = rampCnt + 8'(o);
    end
  end

  // ****************************************************************
  // Lane outputs
  // ****************************************************************
  logic [jlf_pkg::NUM_LANES-1:0][jlf_pkg::LANE_W-1:0] picked;
  logic [jlf_pkg::NUM_LANES-1:0][jlf_pkg::LANE_W-1:0] routed;
  logic [jlf_pkg::NUM_LANES-1:0] routedOn;
  logic useAlt;

  always_comb begin
    for (int l = 0; l < jlf_pkg::NUM_LANES; l++) begin
      if (isPrbs) begin
        picked[l] = prbsWord[l];
      end else if (testReg == jlf_pkg::TEST_CLOCK) begin
        picked[l] = {(jlf_pkg::LANE_W / jlf_pkg::CLK_PAT_W){jlf_pkg::CLK_PATTERN}};
      end else if (testReg == jlf_pkg::TEST_RAMP) begin
        picked[l] = rampWord;
      end else begin
        picked[l] = built[l];
      end
    end
  end

  // With four lanes or fewer, redundancy mirrors the low set onto the high set and silences the low set
  assign useAlt = altReg && (laneCount <= jlf_pkg::LANE_GROUP);
  always_comb begin
    for (int l = 0; l < jlf_pkg::NUM_LANES; l++) begin
      if (!useAlt) begin
        routed[l] = picked[l];
        routedOn[l] = laneOn[l];
      end else if (l >= jlf_pkg::LANE_GROUP) begin
        routed[l] = picked[l - jlf_pkg::LANE_GROUP];
        routedOn[l] = laneOn[l - jlf_pkg::LANE_GROUP];
      end else begin
        routed[l] = '0;
        routedOn[l] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || powerDown) begin
      link.laneData <= '0;
      link.laneDrvEn <= '0;
      link.laneValid <= 1'b0;
    end else begin
      link.laneDrvEn <= (state == jlf_pkg::LINK_DOWN) ? '0 : routedOn;
      if (isBypass) begin
        link.laneValid <= (state != jlf_pkg::LINK_DOWN);
      end else begin
        link.laneValid <= linkUp && (testReg == jlf_pkg::TEST_RAMP || sampleValid);
      end
      link.laneData <= routed;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.linkLayerOn <= 1'b0;
      link.syncHdr <= jlf_pkg::SYNC_NONE;
    end else begin
      link.linkLayerOn <= !isBypass && linkUp;
      if (modeReg == jlf_pkg::MODE_9B_8B10) begin
        link.syncHdr <= jlf_pkg::SYNC_NONE;
      end else begin
        link.syncHdr <= fecReg ? jlf_pkg::SYNC_FEC : jlf_pkg::SYNC_CRC12;
      end
    end
  end

endmodule
`default_nettype wire

/* hw/jlf_host.sv */
// Receiver-side controller: APB registers, power-down relink and PRBS checking
`timescale 1ns/100ps
`default_nettype none
module jlf_host #(
  parameter int FLUSH_CYC = jlf_pkg::FLUSH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the formatter
  jlf_link_if.host link,
  // Received frames
  output logic [jlf_pkg::NUM_LANES-1:0][jlf_pkg::LANE_W-1:0] rxData,
  output logic rxValid
);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic linkEnReg;
  logic pdReg;
  logic opPdReg;
  logic fecReg;
  logic altReg;
  logic [1:0] chenReg;
  logic [3:0] modeReg;
  logic [2:0] testReg;
  logic wrEn;
  logic hit;
  logic [jlf_pkg::CNT_W-1:0] flushCnt;
  logic [jlf_pkg::CNT_W-1:0] errCnt;
  logic pdPrev;
  logic anyErr;

  assign wrEn = psel && penable && pwrite;
  assign hit = (paddr == jlf_pkg::REG_CTRL) || (paddr == jlf_pkg::REG_CFG) ||
               (paddr == jlf_pkg::REG_STAT) || (paddr == jlf_pkg::REG_ERR);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      linkEnReg <= 1'b0;
      pdReg <= 1'b0;
      opPdReg <= 1'b0;
      fecReg <= 1'b0;
      altReg <= 1'b0;
      chenReg <= jlf_pkg::CHEN_RST;
    end else if (wrEn && paddr == jlf_pkg::REG_CTRL) begin
      linkEnReg <= pwdata[jlf_pkg::CTRL_LINK_EN];
      pdReg <= pwdata[jlf_pkg::CTRL_PD];
      opPdReg <= pwdata[jlf_pkg::CTRL_OP_PD];
      fecReg <= pwdata[jlf_pkg::CTRL_FEC];
      altReg <= pwdata[jlf_pkg::CTRL_ALT];
      // All channels off goes through power-down instead
      if (pwdata[jlf_pkg::CTRL_CHEN_LO +: 2] != '0) begin
        chenReg <= pwdata[jlf_pkg::CTRL_CHEN_LO +: 2];
      end
    end
  end

  // Mode and pattern only move while the link is disabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      modeReg <= jlf_pkg::MODE_9B_8B10;
      testReg <= jlf_pkg::TEST_OFF;
    end else if (wrEn && paddr == jlf_pkg::REG_CFG && !linkEnReg) begin
      modeReg <= pwdata[jlf_pkg::CFG_MODE_LO +: 4];
      testReg <= pwdata[jlf_pkg::CFG_TEST_LO +: 3];
    end
  end

  // ****************************************************************
  // Power-down exit: hold the link off and drop data while it flushes
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pdPrev <= 1'b0;
      flushCnt <= '0;
    end else begin
      pdPrev <= pdReg || opPdReg;
      if (pdPrev && !(pdReg || opPdReg)) begin
        flushCnt <= jlf_pkg::CNT_W'(FLUSH_CYC);
      end else if (flushCnt != '0) begin
        flushCnt <= flushCnt - 1'b1;
      end
    end
  end

  assign link.linkEnable = linkEnReg && !pdReg && !opPdReg && (flushCnt == '0);
  assign link.linkMode = modeReg;
  assign link.testSel = testReg;
  assign link.altLane = altReg;
  assign link.chanPairEn = chenReg;
  assign link.syncFec = fecReg;
  assign link.opModePd = opPdReg;
  assign link.pwrDownPin = pdReg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxData <= '0;
      rxValid <= 1'b0;
    end else begin
      rxData <= link.laneData;
      rxValid <= link.laneValid && link.linkLayerOn && (flushCnt == '0);
    end
  end

  // ****************************************************************
  // Self-synchronising PRBS check
  // ****************************************************************
  logic [jlf_pkg::NUM_LANES-1:0] laneErr;
  logic havePrev;
  logic isPrbs;

  assign isPrbs = (testReg >= jlf_pkg::TEST_PRBS7) && (testReg <= jlf_pkg::TEST_PRBS31);

  genvar g;
  generate
    for (g = 0; g < jlf_pkg::NUM_LANES; g++) begin : gChk
      logic [jlf_pkg::PRBS_W-1:0] hist;
      logic [jlf_pkg::PRBS_W+jlf_pkg::LANE_W-1:0] predicted;
      // Predict from the lane's own previous word, so no start phase is assumed
      assign predicted = jlf_pkg::prbsStep(hist, testReg);
      assign laneErr[g] = havePrev && link.laneDrvEn[g] && (link.laneData[g] != predicted[jlf_pkg::LANE_W-1:0]);
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          hist <= '0;
        end else if (link.laneValid) begin
          hist <= link.laneData[g][jlf_pkg::PRBS_W-1:0];
        end
      end
    end
  endgenerate

  assign anyErr = isPrbs && link.laneValid && !link.linkLayerOn && (laneErr != '0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      havePrev <= 1'b0;
    end else begin
      havePrev <= isPrbs && link.laneValid && !link.linkLayerOn;
    end
  end

  // A mismatch in the clearing cycle still counts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      errCnt <= '0;
    end else if (anyErr) begin
      errCnt <= (wrEn && paddr == jlf_pkg::REG_ERR) ? jlf_pkg::CNT_W'(1) : errCnt + 1'b1;
    end else if (wrEn && paddr == jlf_pkg::REG_ERR) begin
      errCnt <= '0;
    end
  end

  // ****************************************************************
  // Read data, captured in the setup cycle
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= '0;
      unique case (paddr)
        jlf_pkg::REG_CTRL: begin
          prdata[jlf_pkg::CTRL_LINK_EN] <= linkEnReg;
          prdata[jlf_pkg::CTRL_PD] <= pdReg;
          prdata[jlf_pkg::CTRL_OP_PD] <= opPdReg;
          prdata[jlf_pkg::CTRL_FEC] <= fecReg;
          prdata[jlf_pkg::CTRL_ALT] <= altReg;
          prdata[jlf_pkg::CTRL_CHEN_LO +: 2] <= chenReg;
        end
        jlf_pkg::REG_CFG: begin
          prdata[jlf_pkg::CFG_MODE_LO +: 4] <= modeReg;
          prdata[jlf_pkg::CFG_TEST_LO +: 3] <= testReg;
        end
        jlf_pkg::REG_STAT: begin
          prdata[jlf_pkg::STAT_VALID] <= link.laneValid;
          prdata[jlf_pkg::STAT_FLUSH] <= (flushCnt != '0);
          prdata[jlf_pkg::STAT_LINK_LAYER] <= link.linkLayerOn;
          prdata[jlf_pkg::STAT_DRV_LO +: jlf_pkg::NUM_LANES] <= link.laneDrvEn;
        end
        jlf_pkg::REG_ERR: prdata[jlf_pkg::CNT_W-1:0] <= errCnt;
        default: prdata <= '0;
      endcase
    end
  end

endmodule
`default_nettype wire
